// ---- bench/tcs_asserts.sv ----
// Checker for tcs_top: torque output timing and value relations.
// Assumes tcs_regs.vh on the include path; bound into every tcs_top.
`include "tcs_regs.vh"
module tcs_asserts #(parameter W = 16, parameter NUM_INPUTS = 8, parameter SAMPLE_CYCLES = `TCS_SAMPLE_CYCLES) (
  // Clock, reset and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Inputs and torque outputs
  input wire logic [NUM_INPUTS-1:0] din,
  input wire logic signed [W-1:0] analog_mv,
  input wire logic signed [W-1:0] torque_command,
  input wire logic [W-1:0] torque_limit,
  input wire logic limit_active,
  input wire logic sample_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Shadow state
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] mode;
  logic [63:0] fn;
  logic [1:0] sel;
  logic seen;
  int cnt;
  wire wr_done = psel && penable && pwrite && pready;
  // Mode and pin functions follow completed writes; tick spacing counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= `TCS_RST_MODE;
      fn <= '0;
      seen <= 1'b0;
      cnt <= 0;
    end else begin
      if (wr_done && paddr == `TCS_OFF_MODE) mode <= pwdata[2:0];
      if (wr_done && paddr == `TCS_OFF_ASSIGN_LO) fn[31:0] <= pwdata;
      if (wr_done && paddr == `TCS_OFF_ASSIGN_HI) fn[63:32] <= pwdata;
      seen <= seen | sample_strobe;
      cnt <= sample_strobe ? 0 : cnt + 1;
    end
  end
  // Select code as the pins and their functions give it now
  always_comb begin
    sel = 2'b00;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (din[i] && fn[i*8 +: 8] == `TCS_FUNC_SEL_LOW) sel[0] = 1'b1;
      if (din[i] && fn[i*8 +: 8] == `TCS_FUNC_SEL_HIGH) sel[1] = 1'b1;
    end
  end
  property p_zero; sample_strobe && $past(mode) == `TCS_MODE_ZERO && $past(sel) == 2'b00 |-> torque_command == 0;
  endproperty
  a_zero: assert property (p_zero) else $error("nonzero torque in zero mode");
  property p_span; sample_strobe && $past(mode) <= `TCS_MODE_ZERO && $past(sel) != 2'b00
    |-> torque_command >= -300 && torque_command <= 300; endproperty
  a_span: assert property (p_span) else $error("setpoint torque out of span");
  property p_hold; !sample_strobe |-> $stable(torque_command) && $stable(limit_active); endproperty
  a_hold: assert property (p_hold) else $error("output moved between ticks");
  property p_lim_flag; sample_strobe |-> limit_active == ($past(mode) > `TCS_MODE_ZERO); endproperty
  a_lim_flag: assert property (p_lim_flag) else $error("limit flag wrong for mode");
  property p_lim_cmd; limit_active |-> torque_command == 0; endproperty
  a_lim_cmd: assert property (p_lim_cmd) else $error("command in limit mode");
  // Only the analog path is clamped to full scale; setpoints may exceed a small full scale
  property p_clamp; sample_strobe && $past(mode) == `TCS_MODE_ANALOG && $past(sel) == 2'b00
    |-> int'(torque_command) <= int'(torque_limit) && int'(torque_command) >= -int'(torque_limit); endproperty
  a_clamp: assert property (p_clamp) else $error("command beyond full scale");
  property p_period; sample_strobe && seen |-> cnt == SAMPLE_CYCLES - 1; endproperty
  a_period: assert property (p_period) else $error("tick spacing wrong");
  property p_pulse; sample_strobe |=> !sample_strobe; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe longer than a cycle");
endmodule // tcs_asserts

bind tcs_top tcs_asserts #(.W(W), .NUM_INPUTS(NUM_INPUTS), .SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .din(din), .analog_mv(analog_mv),
  .torque_command(torque_command), .torque_limit(torque_limit), .limit_active(limit_active),
  .sample_strobe(sample_strobe));

// ---- bench/tcs_host_model.sv ----
// Host controller model: select pins and analog reference.
// Assumes the bench names a select code and a voltage each cycle.
module tcs_host_model #(parameter int LO_PIN = 2, parameter int HI_PIN = 5) (
  // Requests from the bench
  input wire logic pclk,
  input wire logic [1:0] sel,
  input wire logic signed [15:0] mv_req,
  // Toward the block
  output logic [7:0] din,
  output logic signed [15:0] analog_mv
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pins;
  // Spare pins take random values every cycle so a wrong pin pick shows; din gets one assignment per edge
  always @(posedge pclk) begin
    pins = 8'($urandom);
    pins[LO_PIN] = sel[0];
    pins[HI_PIN] = sel[1];
    din <= pins;
    analog_mv <= (mv_req > 10000) ? 16'sd10000 : (mv_req < -10000) ? -16'sd10000 : mv_req;
  end
endmodule // tcs_host_model

// ---- bench/torque_command_selector_tb.sv ----
// Self-checking bench for tcs_top with a host model on the select pins.
// Assumes tcs_regs.vh on the include path; short tick of 4 cycles.
`include "tcs_regs.vh"
module torque_command_selector_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, limit_active, sample_strobe;
  logic [7:0] din;
  logic signed [15:0] analog_mv, torque_command;
  logic signed [15:0] mv_req = 16'sh0000;
  logic [15:0] torque_limit;
  logic [1:0] sel = 2'b00;
  int n_errors = 0;
  int check_count = 0;
  // ----------------------------------------
  // Clock, parts and helpers
  // ----------------------------------------
  always #2 pclk = ~pclk;
  tcs_host_model HOST (.pclk(pclk), .sel(sel), .mv_req(mv_req), .din(din), .analog_mv(analog_mv));
  tcs_top #(.SAMPLE_CYCLES(SC)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .din(din), .analog_mv(analog_mv), .torque_command(torque_command), .torque_limit(torque_limit),
    .limit_active(limit_active), .sample_strobe(sample_strobe));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      n_errors++;
    end
  endtask
  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    chk(pready, 1'b1, "no ready");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe, input string msg);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk(r, x, msg);
    chk(e, xe, msg);
  endtask
  // Two ticks, so the second surely saw the new inputs
  task automatic tick2;
    int n;
    n = 0;
    repeat (2) begin
      @(posedge pclk);
      while (sample_strobe !== 1'b1 && n < 50) begin
        @(posedge pclk);
        n++;
      end
      chk(sample_strobe, 1'b1, "no tick");
    end
    @(negedge pclk);
  endtask
  function automatic int sat(int v);
    return v > 300 ? 300 : v < -300 ? -300 : v;
  endfunction
  function automatic int exp_an(int fs, int mv, int off);
    int t;
    t = fs * (mv - off) / 10000;
    return t > fs ? fs : t < -fs ? -fs : t;
  endfunction
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Cut a hang well past the roughly 1000 cycles the run needs
  initial begin
    #100000;
    n_errors++;
    summarize();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    static int sp[3] = '{150, -300, 400};
    static logic [31:0] rst[8] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h64, 32'h0, 32'h0, 32'h0};
    int m, c, fs, off, mv, cmd, lim;
    void'($urandom(32'hA8D2));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(8'(i * 4), rst[i], 1'b0, "reset value");
    rd(8'h24, 32'h00000000, 1'b1, "unmapped read");
    wr(`TCS_OFF_ASSIGN_LO, 32'h00100000);
    wr(`TCS_OFF_ASSIGN_HI, 32'hA5001100);
    for (int i = 0; i < 3; i++) wr(8'(4 + i * 4), 32'(sp[i]));
    for (int i = 0; i < 3; i++) rd(8'(4 + i * 4), {16'h0000, 16'(sat(sp[i]))}, 1'b0, "setpoint");
    // Every mode with every code, then analog mode at random
    for (int i = 0; i < 48; i++) begin
      m = i < 32 ? i / 4 : 0;
      c = i < 32 ? i % 4 : 0;
      fs = i == 32 ? 300 : $urandom_range(500);
      off = i == 32 ? -2000 : $urandom_range(6000) - 3000;
      mv = i == 32 ? 10000 : $urandom_range(20000) - 10000;
      wr(`TCS_OFF_MODE, 32'(m));
      wr(`TCS_OFF_FULL_SCALE, 32'(fs));
      wr(`TCS_OFF_ANALOG_OFFSET, 32'(off));
      @(posedge pclk);
      sel <= 2'(c);
      mv_req <= 16'(mv);
      tick2();
      cmd = m > 1 ? 0 : c != 0 ? sat(sp[c-1]) : m == 1 ? 0 : exp_an(fs, mv, off);
      lim = (m > 1 && c != 0) ? (sat(sp[c-1]) < 0 ? -sat(sp[c-1]) : sat(sp[c-1])) : fs;
      chk(torque_command, cmd, "command");
      chk(torque_limit, lim, "limit");
      chk(limit_active, m > 1, "limit flag");
      rd(`TCS_OFF_STATUS, {9'h000, 3'(m), 1'b0, m > 1, 2'(c), 16'(cmd)}, 1'b0, "status");
    end
    summarize();
  end
endmodule // torque_command_selector_tb

// ---- rtl/tcs_regs.vh ----
// Constants of the torque command selector: register map, fields, resets, codes, timing.
// Assumes a 32-bit APB slave with word-aligned registers and a 250 MHz pclk.
`ifndef TCS_REGS_VH
`define TCS_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TCS_OFF_MODE 8'h00
`define TCS_OFF_SETPOINT_ONE 8'h04
`define TCS_OFF_SETPOINT_TWO 8'h08
`define TCS_OFF_SETPOINT_THREE 8'h0C
`define TCS_OFF_FULL_SCALE 8'h10
`define TCS_OFF_ANALOG_OFFSET 8'h14
`define TCS_OFF_ASSIGN_LO 8'h18
`define TCS_OFF_ASSIGN_HI 8'h1C
`define TCS_OFF_STATUS 8'h20

// ----------------------------------------
// Fields and codes
// ----------------------------------------
`define TCS_MODE_W 3
`define TCS_MODE_ANALOG 3'h0
`define TCS_MODE_ZERO 3'h1
`define TCS_MODE_PULSE_POS 3'h2
`define TCS_MODE_INT_POS 3'h3
`define TCS_MODE_VELOCITY 3'h4
`define TCS_MODE_ZERO_VEL 3'h5
`define TCS_FUNC_SEL_LOW 8'h10
`define TCS_FUNC_SEL_HIGH 8'h11
`define TCS_STAT_SEL_LSB 16
`define TCS_STAT_LIMIT_BIT 18
`define TCS_STAT_MODE_LSB 20

// ----------------------------------------
// Ranges and scaling
// ----------------------------------------
`define TCS_SETPOINT_MAX 16'h012C
`define TCS_FS_DIV 10
`define TCS_OFF_DIV 1000

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TCS_RST_MODE 3'h1
`define TCS_RST_SETPOINT 16'h0000
`define TCS_RST_FULL_SCALE 16'h0064
`define TCS_RST_ANALOG_OFFSET 16'h0000
`define TCS_RST_ASSIGN 32'h00000000

// ----------------------------------------
// Timing
// ----------------------------------------
`define TCS_CLK_PERIOD_NS 4
`define TCS_SAMPLE_PERIOD_NS 1000
`define TCS_SAMPLE_CYCLES (`TCS_SAMPLE_PERIOD_NS / `TCS_CLK_PERIOD_NS)

`endif

// ---- rtl/tcs_scale.v ----
// Analog torque scaling: offset removal, full-scale gain and clamp.
// Assumes the input is a signed millivolt sample; result in percent of rated torque.
`include "tcs_regs.vh"

module tcs_scale #(
  parameter W = 16
) (
  // Analog sample and settings
  input wire signed [W-1:0] analog_mv,
  input wire [W-1:0] full_scale,
  input wire signed [W-1:0] offset_mv,
  // Scaled command
  output reg signed [W-1:0] torque
);

  localparam PW = 2 * W + 3;
  localparam signed [PW-1:0] DIV = `TCS_FS_DIV * `TCS_OFF_DIV;

  wire signed [W+1:0] diff;
  wire signed [PW-1:0] prod;
  wire signed [PW-1:0] quot;
  wire signed [PW-1:0] fs_pos;
  wire signed [PW-1:0] fs_neg;

  // Offset first, so zero torque can sit at a nonzero voltage
  assign diff = {{2{analog_mv[W-1]}}, analog_mv} - {{2{offset_mv[W-1]}}, offset_mv};
  assign prod = {{(PW-W-2){diff[W+1]}}, diff} * $signed({{(PW-W){1'b0}}, full_scale});
  // Division truncates toward zero, symmetric for both signs
  assign quot = prod / DIV;
  assign fs_pos = $signed({{(PW-W){1'b0}}, full_scale});
  assign fs_neg = -fs_pos;

  // Clamp to plus or minus full scale
  always @* begin
    if (quot > fs_pos) begin
      torque = fs_pos[W-1:0];
    end else if (quot < fs_neg) begin
      torque = fs_neg[W-1:0];
    end else begin
      torque = quot[W-1:0];
    end
  end

endmodule // tcs_scale

// ---- rtl/tcs_top.v ----
// Torque command selector: APB registers, select decode, command and limit output.
// Assumes synchronous digital inputs and an analog sample already digitised in millivolts.
`include "tcs_regs.vh"

module tcs_top #(
  parameter W = 16,
  parameter NUM_INPUTS = 8,
  parameter SAMPLE_CYCLES = `TCS_SAMPLE_CYCLES
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Configurable digital inputs
  input wire [NUM_INPUTS-1:0] din,
  // Digitised analog torque reference, signed millivolts
  input wire signed [W-1:0] analog_mv,
  // Torque outputs, percent of rated torque
  output reg signed [W-1:0] torque_command,
  output reg [W-1:0] torque_limit,
  output reg limit_active,
  output reg sample_strobe
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [`TCS_MODE_W-1:0] mode;
  reg signed [W-1:0] torque_setpoint_one;
  reg signed [W-1:0] torque_setpoint_two;
  reg signed [W-1:0] torque_setpoint_three;
  reg [W-1:0] analog_torque_full_scale;
  reg signed [W-1:0] analog_torque_offset;
  reg [63:0] input_function_assignments;
  reg [1:0] sel_code;
  reg [15:0] sample_cnt;

  wire wr_en;
  wire setup;
  wire signed [W-1:0] wdata_clamped;
  wire signed [W-1:0] analog_torque;
  wire [NUM_INPUTS-1:0] hit_low;
  wire [NUM_INPUTS-1:0] hit_high;
  wire torque_select_low;
  wire torque_select_high;
  wire zero_torque_mode;
  wire torque_mode;
  wire sample_tick;

  assign wr_en = psel & penable & pwrite;
  assign setup = psel & ~penable;

  // ----------------------------------------
  // Setpoint range clamp
  // ----------------------------------------
  // Writes outside +-300% are saturated rather than refused
  assign wdata_clamped = ($signed(pwdata[W-1:0]) > $signed(`TCS_SETPOINT_MAX)) ? `TCS_SETPOINT_MAX :
                         ($signed(pwdata[W-1:0]) < -$signed(`TCS_SETPOINT_MAX)) ? -`TCS_SETPOINT_MAX :
                         pwdata[W-1:0];

  // Register writes, taken in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= `TCS_RST_MODE;
      torque_setpoint_one <= `TCS_RST_SETPOINT;
      torque_setpoint_two <= `TCS_RST_SETPOINT;
      torque_setpoint_three <= `TCS_RST_SETPOINT;
      analog_torque_full_scale <= `TCS_RST_FULL_SCALE;
      analog_torque_offset <= `TCS_RST_ANALOG_OFFSET;
      input_function_assignments <= {`TCS_RST_ASSIGN, `TCS_RST_ASSIGN};
    end else if (wr_en) begin
      case (paddr)
        `TCS_OFF_MODE: mode <= pwdata[`TCS_MODE_W-1:0];
        `TCS_OFF_SETPOINT_ONE: torque_setpoint_one <= wdata_clamped;
        `TCS_OFF_SETPOINT_TWO: torque_setpoint_two <= wdata_clamped;
        `TCS_OFF_SETPOINT_THREE: torque_setpoint_three <= wdata_clamped;
        `TCS_OFF_FULL_SCALE: analog_torque_full_scale <= pwdata[W-1:0];
        `TCS_OFF_ANALOG_OFFSET: analog_torque_offset <= pwdata[W-1:0];
        `TCS_OFF_ASSIGN_LO: input_function_assignments[31:0] <= pwdata;
        `TCS_OFF_ASSIGN_HI: input_function_assignments[63:32] <= pwdata;
        default: mode <= mode;
      endcase
    end
  end

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  // Read data captured in setup, so the access phase needs no wait state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
        case (paddr)
          `TCS_OFF_MODE: prdata <= {{(32-`TCS_MODE_W){1'b0}}, mode};
          `TCS_OFF_SETPOINT_ONE: prdata <= {{(32-W){1'b0}}, torque_setpoint_one};
          `TCS_OFF_SETPOINT_TWO: prdata <= {{(32-W){1'b0}}, torque_setpoint_two};
          `TCS_OFF_SETPOINT_THREE: prdata <= {{(32-W){1'b0}}, torque_setpoint_three};
          `TCS_OFF_FULL_SCALE: prdata <= {{(32-W){1'b0}}, analog_torque_full_scale};
          `TCS_OFF_ANALOG_OFFSET: prdata <= {{(32-W){1'b0}}, analog_torque_offset};
          `TCS_OFF_ASSIGN_LO: prdata <= input_function_assignments[31:0];
          `TCS_OFF_ASSIGN_HI: prdata <= input_function_assignments[63:32];
          `TCS_OFF_STATUS: begin
            prdata[W-1:0] <= torque_command;
            prdata[`TCS_STAT_SEL_LSB+1:`TCS_STAT_SEL_LSB] <= sel_code;
            prdata[`TCS_STAT_LIMIT_BIT] <= limit_active;
            prdata[`TCS_STAT_MODE_LSB+`TCS_MODE_W-1:`TCS_STAT_MODE_LSB] <= mode;
          end
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Input function mapping
  // ----------------------------------------
  // Several inputs with the same function are ORed together
  genvar i;
  generate
    for (i = 0; i < NUM_INPUTS; i = i + 1) begin : g_map
      assign hit_low[i] = din[i] & (input_function_assignments[8*i+7:8*i] == `TCS_FUNC_SEL_LOW);
      assign hit_high[i] = din[i] & (input_function_assignments[8*i+7:8*i] == `TCS_FUNC_SEL_HIGH);
    end
  endgenerate

  assign torque_select_low = |hit_low;
  assign torque_select_high = |hit_high;
  assign zero_torque_mode = (mode == `TCS_MODE_ZERO);
  assign torque_mode = (mode == `TCS_MODE_ANALOG) | zero_torque_mode;

  // ----------------------------------------
  // Analog scaling
  // ----------------------------------------
  tcs_scale #(
    .W(W)
  ) u_scale (
    .analog_mv(analog_mv),
    .full_scale(analog_torque_full_scale),
    .offset_mv(analog_torque_offset),
    .torque(analog_torque)
  );

  // ----------------------------------------
  // Sample period timer
  // ----------------------------------------
  // One update per control period; the loop downstream expects a fixed rate
  assign sample_tick = (sample_cnt == SAMPLE_CYCLES - 1);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_cnt <= 16'h0000;
    end else if (sample_tick) begin
      sample_cnt <= 16'h0000;
    end else begin
      sample_cnt <= sample_cnt + 16'h0001;
    end
  end

  // ----------------------------------------
  // Command and limit selection
  // ----------------------------------------
  // Selects are sampled live each period, no trigger input involved
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      torque_command <= {W{1'b0}};
      torque_limit <= {W{1'b0}};
      limit_active <= 1'b0;
      sel_code <= 2'h0;
      sample_strobe <= 1'b0;
    end else begin
      sample_strobe <= sample_tick;
      if (sample_tick) begin
        sel_code <= {torque_select_high, torque_select_low};
        limit_active <= ~torque_mode;
        if (torque_mode) begin
          torque_limit <= analog_torque_full_scale;
          case ({torque_select_high, torque_select_low})
            2'h0: torque_command <= zero_torque_mode ? {W{1'b0}} : analog_torque;
            2'h1: torque_command <= torque_setpoint_one;
            2'h2: torque_command <= torque_setpoint_two;
            2'h3: torque_command <= torque_setpoint_three;
            default: torque_command <= {W{1'b0}};
          endcase
        end else begin
          // Limit magnitude only; sign of a setpoint is not meaningful as a limit
          torque_command <= {W{1'b0}};
          case ({torque_select_high, torque_select_low})
            2'h1: torque_limit <= torque_setpoint_one[W-1] ? -torque_setpoint_one : torque_setpoint_one;
            2'h2: torque_limit <= torque_setpoint_two[W-1] ? -torque_setpoint_two : torque_setpoint_two;
            2'h3: torque_limit <= torque_setpoint_three[W-1] ? -torque_setpoint_three : torque_setpoint_three;
            default: torque_limit <= analog_torque_full_scale;
          endcase
        end
      end
    end
  end

endmodule // tcs_top
